//--- hdl/pmc_params.svh
`ifndef PMC_PARAMS_SVH
`define PMC_PARAMS_SVH

// register offsets on the plain register port (8-bit address)
`define PMC_CLK_CTRL_OFS      8'h00
`define PMC_MODE_STAT_OFS     8'h01
`define PMC_OPTION_OFS        8'h02

// clock control/status field positions
`define PMC_SLOW_EN_BIT       0
`define PMC_PRESCALE_LSB      1
`define PMC_PRESCALE_MSB      2
`define PMC_OSC_IRQ_EN_BIT    3

// option register field positions
`define PMC_WDG_HALT_BIT      0
`define PMC_LONG_DELAY_BIT    1
`define PMC_FLASH_PART_BIT    2

// reset values
`define PMC_CLK_CTRL_RST      8'h00
`define PMC_OPTION_RST        8'h00

// instruction opcodes
`define PMC_HALT_OPCODE       8'h8E
`define PMC_WFI_OPCODE        8'h8F

// interrupt-mask pattern forced on low-power entry
`define PMC_MASK_ENABLE_ALL   2'b10

// stabilisation delays in master clock cycles
`define PMC_DELAY_SHORT       13'd256
`define PMC_DELAY_LONG        13'd4096

`endif

//--- hdl/pmc_pkg.sv
package pmc_pkg;

  // power modes, binary codes
  typedef enum logic [2:0] {
    MODE_RUN         = 3'b000,
    MODE_WAIT        = 3'b001,
    MODE_ACTIVE_HALT = 3'b010,
    MODE_HALT        = 3'b011,
    MODE_STABILISE   = 3'b100
  } pm_mode_t;

endpackage

//--- hdl/power_mode_controller.sv
`timescale 1ns/10ps
`include "pmc_params.svh"

module power_mode_controller (
  input  wire logic       ref_clk,
  input  wire logic       reset_n,
  // register port
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_write,
  input  wire logic       reg_read,
  output logic      [7:0] reg_rdata,
  // cpu core
  input  wire logic       opcode_valid,
  input  wire logic [7:0] opcode,
  input  wire logic       irq_pending,
  input  wire logic       rtc_irq,
  input  wire logic       spi_slave_irq,
  input  wire logic       halt_wake_irq,
  input  wire logic       watchdog_active,
  output logic            cpu_clk_en,
  output logic            irq_mask_force,
  output logic      [1:0] irq_mask_value,
  output logic            cpu_wakeup,
  // clock tree
  output logic            periph_clk_en,
  output logic            rtc_clk_en,
  output logic            osc_enable,
  output logic            watchdog_reset_req,
  output logic      [2:0] power_mode
);

  // ****************************************
  // registers
  // ****************************************

  logic [7:0]       clock_ctrl_status_reg; // slow and osc irq control
  logic [7:0]       option_reg;            // option byte image
  pmc_pkg::pm_mode_t mode_reg;             // current power mode
  pmc_pkg::pm_mode_t mode_next;
  logic             slow_wait_reg;         // wait entered while slow

  // ****************************************
  // field decode
  // ****************************************

  logic       slow_enable;
  logic [1:0] slow_prescale_sel;
  logic       osc_irq_enable;
  logic       watchdog_halt_option;
  logic       long_delay;
  logic       flash_part;

  assign slow_enable       = clock_ctrl_status_reg[`PMC_SLOW_EN_BIT];
  assign slow_prescale_sel =
    clock_ctrl_status_reg[`PMC_PRESCALE_MSB:`PMC_PRESCALE_LSB];
  assign osc_irq_enable    = clock_ctrl_status_reg[`PMC_OSC_IRQ_EN_BIT];
  assign watchdog_halt_option = option_reg[`PMC_WDG_HALT_BIT];
  assign long_delay        = option_reg[`PMC_LONG_DELAY_BIT];
  assign flash_part        = option_reg[`PMC_FLASH_PART_BIT];

  // ****************************************
  // instruction and wake decode
  // ****************************************

  logic halt_instr;
  logic wait_for_irq_instr;
  logic halt_to_reset;    // watchdog reset instead of halt
  logic active_wake;      // wake source for active-halt
  logic full_wake;        // wake source for full halt
  logic in_run;

  assign in_run             = (mode_reg == pmc_pkg::MODE_RUN);
  assign halt_instr         = in_run && opcode_valid &&
                              (opcode == `PMC_HALT_OPCODE);
  assign wait_for_irq_instr = in_run && opcode_valid &&
                              (opcode == `PMC_WFI_OPCODE);
  // watchdog reset only when halt would be full halt
  assign halt_to_reset      = halt_instr && watchdog_active &&
                              watchdog_halt_option &&
                              !osc_irq_enable;
  // flash parts ignore all but rtc
  assign active_wake        = rtc_irq ||
                              (!flash_part && irq_pending);
  assign full_wake          = halt_wake_irq || spi_slave_irq;

  // ****************************************
  // submodules
  // ****************************************

  logic cpu_tick;   // divided cpu/peripheral rate
  logic stab_start; // oscillator restart pulse
  logic stab_done;  // delay elapsed

  slow_clock_divider u_div (
    .ref_clk           (ref_clk),
    .reset_n           (reset_n),
    .slow_enable       (slow_enable),
    .slow_prescale_sel (slow_prescale_sel),
    .tick              (cpu_tick)
  );

  // delay counts on master rate while oscillator restarts
  stabilise_counter u_stab (
    .ref_clk    (ref_clk),
    .reset_n    (reset_n),
    .start      (stab_start),
    .cpu_tick   (1'b1),
    .long_delay (long_delay),
    .done       (stab_done)
  );

  assign stab_start = (mode_reg == pmc_pkg::MODE_HALT) && full_wake;

  // ****************************************
  // mode sequencer
  // ****************************************

  // next mode selection
  always_comb begin
    mode_next = mode_reg;
    unique case (mode_reg)
      pmc_pkg::MODE_RUN: begin
        if (halt_instr && !halt_to_reset) begin
          // pending irq wakes at once after mask is opened
          if (irq_pending) begin
            mode_next = pmc_pkg::MODE_RUN;
          end else if (osc_irq_enable) begin
            mode_next = pmc_pkg::MODE_ACTIVE_HALT;
          end else begin
            mode_next = pmc_pkg::MODE_HALT;
          end
        end else if (wait_for_irq_instr && !irq_pending) begin
          mode_next = pmc_pkg::MODE_WAIT;
        end
      end
      pmc_pkg::MODE_WAIT: begin
        if (irq_pending) begin
          mode_next = pmc_pkg::MODE_RUN;
        end
      end
      pmc_pkg::MODE_ACTIVE_HALT: begin
        if (active_wake) begin
          mode_next = pmc_pkg::MODE_RUN;
        end
      end
      pmc_pkg::MODE_HALT: begin
        if (full_wake) begin
          mode_next = pmc_pkg::MODE_STABILISE;
        end
      end
      pmc_pkg::MODE_STABILISE: begin
        if (stab_done) begin
          mode_next = pmc_pkg::MODE_RUN;
        end
      end
      default: begin
        mode_next = pmc_pkg::MODE_RUN;
      end
    endcase
  end

  // mode register; reset lands in run
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      mode_reg <= pmc_pkg::MODE_RUN;
    end else begin
      mode_reg <= mode_next;
    end
  end

  // slow-wait marker, kept while waiting
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      slow_wait_reg <= 1'b0;
    end else if (in_run && mode_next == pmc_pkg::MODE_WAIT) begin
      slow_wait_reg <= slow_enable;
    end else if (mode_next == pmc_pkg::MODE_RUN) begin
      slow_wait_reg <= 1'b0;
    end
  end

  // ****************************************
  // clock gating and core controls
  // ****************************************

  logic entering_low;   // halt (not watchdog reset) or wfi opcode taken this cycle
  logic cpu_run_next;
  logic periph_next;
  logic rtc_next;
  logic osc_next;
  logic wake_next;

  assign entering_low = (halt_instr && !halt_to_reset) ||
                        wait_for_irq_instr;
  assign cpu_run_next = (mode_next == pmc_pkg::MODE_RUN) && cpu_tick;
  // wait keeps peripherals, slow-wait at divided rate
  assign periph_next  = ((mode_next == pmc_pkg::MODE_RUN) ||
                         (mode_next == pmc_pkg::MODE_WAIT)) &&
                        cpu_tick;
  // rtc runs except in halt and stabilise
  assign rtc_next     = (mode_next != pmc_pkg::MODE_HALT) &&
                        (mode_next != pmc_pkg::MODE_STABILISE);
  assign osc_next     = (mode_next != pmc_pkg::MODE_HALT);
  // leaving a low-power mode restarts the core (core stacks cc)
  assign wake_next    = !in_run && (mode_next == pmc_pkg::MODE_RUN);

  // registered outputs toward core and clock tree
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      cpu_clk_en         <= 1'b1;
      periph_clk_en      <= 1'b1;
      rtc_clk_en         <= 1'b1;
      osc_enable         <= 1'b1;
      irq_mask_force     <= 1'b0;
      irq_mask_value     <= 2'b00;
      cpu_wakeup         <= 1'b0;
      watchdog_reset_req <= 1'b0;
      power_mode         <= 3'b000;
    end else begin
      cpu_clk_en         <= cpu_run_next;
      periph_clk_en      <= periph_next;
      rtc_clk_en         <= rtc_next;
      osc_enable         <= osc_next;
      irq_mask_force     <= entering_low;
      irq_mask_value     <= `PMC_MASK_ENABLE_ALL;
      cpu_wakeup         <= wake_next;
      watchdog_reset_req <= halt_to_reset;
      power_mode         <= mode_next;
    end
  end

  // ****************************************
  // register port
  // ****************************************

  logic       hit_ctrl;
  logic       hit_stat;
  logic       hit_opt;
  logic [7:0] rdata_next;

  assign hit_ctrl = (reg_addr == `PMC_CLK_CTRL_OFS);
  assign hit_stat = (reg_addr == `PMC_MODE_STAT_OFS);
  assign hit_opt  = (reg_addr == `PMC_OPTION_OFS);

  // unmapped addresses read zero; stat shows mode and slow-wait
  assign rdata_next = hit_ctrl ? clock_ctrl_status_reg :
                      hit_stat ? {4'h0, slow_wait_reg, mode_reg} :
                      hit_opt  ? option_reg : 8'h00;

  // software writes; low bits only are implemented
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      clock_ctrl_status_reg <= `PMC_CLK_CTRL_RST;
      option_reg            <= `PMC_OPTION_RST;
    end else if (reg_write) begin
      if (hit_ctrl) begin
        clock_ctrl_status_reg <= {4'h0, reg_wdata[3:0]};
      end
      if (hit_opt) begin
        option_reg <= {5'h00, reg_wdata[2:0]};
      end
    end
  end

  // read data valid the cycle after the strobe
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= reg_read ? rdata_next : 8'h00;
    end
  end

endmodule // power_mode_controller

//--- hdl/slow_clock_divider.sv
`timescale 1ns/10ps
`include "pmc_params.svh"

// ****************************************
// divided cpu/peripheral clock enable
// ****************************************
module slow_clock_divider (
  input  wire logic       ref_clk,
  input  wire logic       reset_n,
  input  wire logic       slow_enable,
  input  wire logic [1:0] slow_prescale_sel,
  output logic            tick
);

  logic [3:0] count_reg;   // free-running divider
  logic [3:0] count_next;
  logic [3:0] limit;       // terminal count for selected ratio
  logic       tick_next;

  // ratio 2,4,8,16: terminal = 2^(sel+1)-1
  // shift amount kept 3 bits wide so sel=3 gives 4, not a wrap to 0
  assign limit      = 4'(({3'b000, 1'b1} << ({1'b0, slow_prescale_sel}
                      + 3'd1)) - 4'h1);
  assign tick_next  = !slow_enable || (count_reg >= limit);
  assign count_next = tick_next ? 4'h0 : 4'(count_reg + 4'h1);

  // tick every cycle when not slow, else once per ratio
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      count_reg <= 4'h0;
      tick      <= 1'b1;
    end else begin
      count_reg <= count_next;
      tick      <= tick_next;
    end
  end

endmodule // slow_clock_divider

//--- hdl/stabilise_counter.sv
`timescale 1ns/10ps
`include "pmc_params.svh"

// ****************************************
// oscillator stabilisation counter
// ****************************************
module stabilise_counter (
  input  wire logic ref_clk,
  input  wire logic reset_n,
  input  wire logic start,
  input  wire logic cpu_tick,
  input  wire logic long_delay,
  output logic      done
);

  logic [12:0] count_reg;  // cpu cycles counted so far
  logic [12:0] target;     // selected length
  logic        busy_reg;

  assign target = long_delay ? `PMC_DELAY_LONG : `PMC_DELAY_SHORT;

  // counts cpu cycles from oscillator restart
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      count_reg <= 13'h0000;
      busy_reg  <= 1'b0;
      done      <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        count_reg <= 13'h0000;
        busy_reg  <= 1'b1;
      end else if (busy_reg && cpu_tick) begin
        if (count_reg == 13'(target - 13'h0001)) begin
          busy_reg <= 1'b0;
          done     <= 1'b1;
        end else begin
          count_reg <= 13'(count_reg + 13'h0001);
        end
      end
    end
  end

endmodule // stabilise_counter

//--- verif/cpu_core_model.sv
`timescale 1ns/10ps

// ****************************************
// core and interrupt stand-in
// ****************************************
module cpu_core_model (
  input  wire logic       ref_clk,
  input  wire logic       reset_n,
  input  wire logic       op_req,     // bench asks for an instruction
  input  wire logic [7:0] op_byte,
  input  wire logic [3:0] irq_set,    // pending, rtc, spi, other
  input  wire logic       irq_clr,
  input  wire logic       cpu_clk_en,
  input  wire logic       cpu_wakeup,
  output logic            opcode_valid,
  output logic      [7:0] opcode,
  output logic            irq_pending,
  output logic            rtc_irq,
  output logic            spi_slave_irq,
  output logic            halt_wake_irq
);
  logic       op_hold_reg;  // instruction waiting for a cpu cycle
  logic [7:0] op_reg;
  logic [3:0] irq_reg;      // level requests until serviced

  // a stopped core executes nothing
  assign opcode_valid = op_hold_reg & cpu_clk_en;
  // junk on the bus when idle, never a stale opcode
  assign opcode = opcode_valid ? op_reg : ~op_reg;
  assign {halt_wake_irq, spi_slave_irq, rtc_irq, irq_pending} = irq_reg;

  // service entry (wakeup or irq_clr) drops requests
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      op_hold_reg <= 1'b0;
      op_reg      <= 8'h00;
      irq_reg     <= 4'h0;
    end else begin
      if (op_req) begin
        op_hold_reg <= 1'b1;
        op_reg      <= op_byte;
      end else if (opcode_valid) begin
        op_hold_reg <= 1'b0;
      end
      if (cpu_wakeup | irq_clr) begin
        irq_reg <= 4'h0;
      end else begin
        irq_reg <= irq_reg | irq_set;
      end
    end
  end
endmodule  // cpu_core_model

//--- verif/power_mode_chk.sv
`timescale 1ns/10ps
`include "pmc_params.svh"

// ****************************************
// port checker for the mode sequencer
// ****************************************
module power_mode_chk (
  input wire logic       ref_clk,
  input wire logic       reset_n,
  input wire logic       opcode_valid,
  input wire logic [7:0] opcode,
  input wire logic       irq_pending,
  input wire logic       rtc_irq,
  input wire logic       spi_slave_irq,
  input wire logic       halt_wake_irq,
  input wire logic       watchdog_active,
  input wire logic       cpu_clk_en,
  input wire logic       irq_mask_force,
  input wire logic [1:0] irq_mask_value,
  input wire logic       cpu_wakeup,
  input wire logic       periph_clk_en,
  input wire logic       rtc_clk_en,
  input wire logic       osc_enable,
  input wire logic       watchdog_reset_req,
  input wire logic [2:0] power_mode
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  logic        in_stab;       // oscillator settling
  logic        run_op;        // instruction taken in run mode
  logic [12:0] stab_cnt_reg;  // cycles spent settling
  assign in_stab = power_mode == pmc_pkg::MODE_STABILISE;
  assign run_op = opcode_valid && power_mode == pmc_pkg::MODE_RUN;

  // counter clears outside settling so each exit sees one span
  always_ff @(posedge ref_clk) begin
    if (!reset_n || !in_stab) begin
      stab_cnt_reg <= 13'h0;
    end else begin
      stab_cnt_reg <= stab_cnt_reg + 13'h1;
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  AST_RESET_RUN: assert property ($rose(reset_n) |->
    power_mode == pmc_pkg::MODE_RUN && cpu_clk_en && osc_enable)
    else $error("not in run after reset");
  AST_WAIT_ENTRY: assert property (run_op && !irq_pending &&
    opcode == `PMC_WFI_OPCODE |=> power_mode == pmc_pkg::MODE_WAIT &&
    !cpu_clk_en && irq_mask_force) else $error("bad wait entry");
  AST_MASK_PATTERN: assert property (irq_mask_force |->
    irq_mask_value == `PMC_MASK_ENABLE_ALL) else $error("bad mask value");
  AST_HALT_ENTRY: assert property (run_op && !irq_pending &&
    !watchdog_active && opcode == `PMC_HALT_OPCODE |=> irq_mask_force &&
    power_mode inside {pmc_pkg::MODE_ACTIVE_HALT, pmc_pkg::MODE_HALT})
    else $error("halt opcode not taken");
  AST_PENDING_STAY: assert property (run_op && irq_pending &&
    opcode inside {`PMC_HALT_OPCODE, `PMC_WFI_OPCODE} |=>
    power_mode == pmc_pkg::MODE_RUN && irq_mask_force)
    else $error("entered low power with irq pending");
  AST_ACT_CLOCKS: assert property (
    power_mode == pmc_pkg::MODE_ACTIVE_HALT |-> rtc_clk_en &&
    osc_enable && !periph_clk_en && !cpu_clk_en)
    else $error("bad clocks in active halt");
  AST_HALT_OSC: assert property (power_mode == pmc_pkg::MODE_HALT |->
    !osc_enable && !periph_clk_en && !cpu_clk_en)
    else $error("oscillator on in halt");
  AST_RTC_WAKE: assert property (rtc_irq &&
    power_mode == pmc_pkg::MODE_ACTIVE_HALT |=> cpu_wakeup && cpu_clk_en &&
    power_mode == pmc_pkg::MODE_RUN) else $error("slow rtc wake");
  AST_HALT_WAKE: assert property ((spi_slave_irq || halt_wake_irq) &&
    power_mode == pmc_pkg::MODE_HALT |=> in_stab && osc_enable)
    else $error("halt wake missed");
  AST_STAB_LEN: assert property ($fell(in_stab) |->
    power_mode == pmc_pkg::MODE_RUN && cpu_wakeup &&
    stab_cnt_reg inside {[13'd255:13'd258], [13'd4095:13'd4098]})
    else $error("bad settling length");
  AST_WDG_CAUSE: assert property (watchdog_reset_req |->
    $past(opcode_valid) && $past(opcode) == `PMC_HALT_OPCODE &&
    $past(watchdog_active) && power_mode == pmc_pkg::MODE_RUN)
    else $error("stray watchdog reset");
  AST_WAKE_PULSE: assert property (cpu_wakeup |=> !cpu_wakeup)
    else $error("wakeup longer than one cycle");

  cover property (rtc_irq && power_mode == pmc_pkg::MODE_ACTIVE_HALT);
  cover property ($fell(in_stab));
  cover property (watchdog_reset_req);
endmodule  // power_mode_chk

//--- verif/test_power_mode_controller.sv
`timescale 1ns/10ps
`include "pmc_params.svh"

// ****************************************
// bench for the power mode controller
// ****************************************
module test_power_mode_controller;
  logic       ref_clk, reset_n, reg_write, reg_read, opcode_valid;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, opcode, op_byte;
  logic       irq_pending, rtc_irq, spi_slave_irq, halt_wake_irq;
  logic       watchdog_active, cpu_clk_en, irq_mask_force, cpu_wakeup;
  logic       periph_clk_en, rtc_clk_en, osc_enable, watchdog_reset_req;
  logic [1:0] irq_mask_value;
  logic [2:0] power_mode;
  logic       op_req, irq_clr;
  logic [3:0] irq_set;
  int         n_mismatch = 0;
  int         samples_checked = 0;
  int         wdg_cnt = 0;  // watchdog reset pulses seen
  int         n;

  power_mode_controller power_mode_controller_i (.*);
  cpu_core_model cpu_core_model_i (.*);

  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) if (watchdog_reset_req === 1'b1) wdg_cnt++;

  // ****************************************
  // tasks
  // ****************************************
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk) {reg_write, reg_addr, reg_wdata} <= {1'b1, a, d};
    @(posedge ref_clk) reg_write <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic reg_rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge ref_clk) {reg_read, reg_addr} <= {1'b1, a};
    @(posedge ref_clk) reg_read <= 1'b0;
    #1 check(reg_rdata, exp);
  endtask
  task automatic run_op(input logic [7:0] b);
    @(posedge ref_clk) {op_req, op_byte} <= {1'b1, b};
    @(posedge ref_clk) op_req <= 1'b0;
  endtask
  task automatic irq_ctl(input logic [3:0] s, input logic c);
    @(posedge ref_clk) {irq_set, irq_clr} <= {s, c};
    @(posedge ref_clk) {irq_set, irq_clr} <= 5'h00;
  endtask
  // bounded wait, so a stuck mode costs one mismatch, not a hang
  task automatic wait_mode(input logic [2:0] m, input int lim, output int k);
    for (k = 0; power_mode !== m && k < lim; k++) @(posedge ref_clk) #1;
    check({5'h0, power_mode}, {5'h0, m});
  endtask
  task automatic gap(output int k);
    k = 0;
    do begin
      @(posedge ref_clk) #1;
      k++;
    end while (cpu_clk_en !== 1'b1 && k < 40);
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  initial begin
    {reset_n, reg_write, reg_read, op_req, irq_clr} = 5'h00;
    {reg_addr, reg_wdata, op_byte, irq_set} = 28'h0;
    watchdog_active = 1'b0;
    repeat (8) @(posedge ref_clk);
    reset_n <= 1'b1;
    @(posedge ref_clk) #1;
    check({3'h0, power_mode, cpu_clk_en, osc_enable}, 8'h03);
    reg_rd(`PMC_CLK_CTRL_OFS, `PMC_CLK_CTRL_RST);
    reg_rd(`PMC_OPTION_OFS, `PMC_OPTION_RST);
    reg_rd(8'h7F, 8'h00);
    reg_wr(`PMC_CLK_CTRL_OFS, 8'hFF);
    reg_rd(`PMC_CLK_CTRL_OFS, 8'h0F);
    // second gap is a full divider period
    for (int s = 0; s < 4; s++) begin
      reg_wr(`PMC_CLK_CTRL_OFS, {5'h0, s[1:0], 1'b1});
      gap(n);
      gap(n);
      check(n[7:0], 8'h02 << s);
    end
    run_op(`PMC_WFI_OPCODE);
    wait_mode(pmc_pkg::MODE_WAIT, 40, n);
    reg_rd(`PMC_MODE_STAT_OFS, 8'h09);
    irq_ctl(4'h1, 1'b0);
    wait_mode(pmc_pkg::MODE_RUN, 40, n);
    reg_wr(`PMC_CLK_CTRL_OFS, 8'h00);
    run_op(`PMC_WFI_OPCODE);
    wait_mode(pmc_pkg::MODE_WAIT, 5, n);
    check({6'h0, cpu_clk_en, periph_clk_en}, 8'h01);
    irq_ctl(4'h1, 1'b0);
    wait_mode(pmc_pkg::MODE_RUN, 5, n);
    irq_ctl(4'h1, 1'b0);
    run_op(`PMC_HALT_OPCODE);
    repeat (4) @(posedge ref_clk) #1;
    check({5'h0, power_mode}, 8'h00);
    irq_ctl(4'h0, 1'b1);
    // watchdog on, option set, flash part: active halt still safe
    reg_wr(`PMC_OPTION_OFS, 8'h05);
    @(posedge ref_clk) watchdog_active <= 1'b1;
    reg_wr(`PMC_CLK_CTRL_OFS, 8'h08);
    run_op(`PMC_HALT_OPCODE);
    wait_mode(pmc_pkg::MODE_ACTIVE_HALT, 5, n);
    check({4'h0, rtc_clk_en, osc_enable, periph_clk_en, cpu_clk_en},
          8'h0C);
    irq_ctl(4'h9, 1'b0);
    repeat (4) @(posedge ref_clk) #1;
    check({5'h0, power_mode}, 8'h02);
    irq_ctl(4'h2, 1'b0);
    wait_mode(pmc_pkg::MODE_RUN, 3, n);
    check(wdg_cnt[7:0], 8'h00);
    repeat (260) @(posedge ref_clk);
    reg_wr(`PMC_CLK_CTRL_OFS, 8'h00);
    run_op(`PMC_HALT_OPCODE);
    repeat (4) @(posedge ref_clk) #1;
    check({wdg_cnt[4:0], power_mode}, 8'h08);
    @(posedge ref_clk) watchdog_active <= 1'b0;
    // full halt, short then long settling
    for (int d = 0; d < 2; d++) begin
      reg_wr(`PMC_OPTION_OFS, {6'h0, d[0], 1'b0});
      run_op(`PMC_HALT_OPCODE);
      wait_mode(pmc_pkg::MODE_HALT, 5, n);
      check({7'h0, osc_enable}, 8'h00);
      irq_ctl(d ? 4'h8 : 4'h4, 1'b0);
      wait_mode(pmc_pkg::MODE_STABILISE, 3, n);
      wait_mode(pmc_pkg::MODE_RUN, 5000, n);
      check({7'h0, n inside {[254:258], [4094:4098]}}, 8'h01);
    end
    stop_test();
  end

  initial begin
    repeat (20000) @(posedge ref_clk);
    n_mismatch++;
    stop_test();
  end
endmodule  // test_power_mode_controller

bind power_mode_controller power_mode_chk power_mode_chk_i (.*);
